// ### design/rf_tx_protocol_config_loader.sv
// How it works
// R1 - Type A 106 kbit/s loads its six fixed transmitter values.
// R2 - Type A 212 kbit/s loads its six fixed transmitter values.
// R3 - Type A 424 kbit/s loads its six fixed transmitter values.
// R4 - Type A 848 kbit/s loads its six fixed transmitter values.
// R5 - Type B 106 kbit/s loads its six fixed transmitter values.
// R6 - Type B 212 kbit/s loads its six fixed transmitter values.
// R7 - Type B 424 kbit/s loads its six fixed transmitter values.
// R8 - The reception-start delay timer is set by the device, never by the host.
// R9 - All six values are written before another command or transmission starts.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module rf_tx_protocol_config_loader (
  input wire logic aclk, // System clock, 25 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable; low freezes all state
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [7:0] awaddr, // Write byte address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response code
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [7:0] araddr, // Read byte address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response code
  output rf_cfg_pkg::setting_wr_t setting_wr, // One value written per cycle
  output logic rf_tx_on // Transmission allowed
);

  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] next_aw_addr_q;
  logic [31:0] next_w_data_q, next_rdata;
  logic [3:0] next_w_strb_q;
  logic [1:0] next_bresp, next_rresp;
  logic wr_fire;

  rf_cfg_pkg::load_state_t state, next_state;
  logic [2:0] proto_sel, next_proto_sel, active_proto, next_active_proto;
  logic [2:0] idx, next_idx;
  logic tx_enable, next_tx_enable;
  logic done, next_done, refused, next_refused, bad_proto, next_bad_proto;
  logic loaded, next_loaded;
  logic [31:0] setting_mem [0:5];
  logic [31:0] next_setting_mem [0:5];
  logic [31:0] rx_delay, next_rx_delay;
  rf_cfg_pkg::setting_wr_t next_setting_wr;
  logic [31:0] tbl_data;
  logic tbl_ok;
  logic [2:0] req_proto;
  logic req_ok;
  logic [31:0] status_word;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= rf_cfg_pkg::OFS_SETTING0 + 8'h14);
  endfunction

  rf_protocol_table u_active_table (
    .proto(active_proto),
    .index(idx),
    .data(tbl_data),
    .proto_ok(tbl_ok)
  );

  // Checks the code offered with a start command before any write begins.
  rf_protocol_table u_request_table (
    .proto(req_proto),
    .index(3'h0),
    .data(),
    .proto_ok(req_ok)
  );

  assign awready = ce && !aw_held && !bvalid;
  assign wready = ce && !w_held && !bvalid;
  assign arready = ce && !rvalid;
  assign wr_fire = ce && aw_held && w_held && !bvalid;
  assign req_proto = w_strb_q[0] ? w_data_q[2:0] : proto_sel;
  // Transmission waits until the last value of a load has landed.
  assign rf_tx_on = tx_enable && loaded && (state == rf_cfg_pkg::ST_IDLE); // R9

  always_comb
  begin
    status_word = 32'h0;
    status_word[rf_cfg_pkg::ST_BUSY_BIT] = (state != rf_cfg_pkg::ST_IDLE);
    status_word[rf_cfg_pkg::ST_DONE_BIT] = done;
    status_word[rf_cfg_pkg::ST_REFUSED_BIT] = refused;
    status_word[rf_cfg_pkg::ST_BAD_PROTO_BIT] = bad_proto;
    status_word[rf_cfg_pkg::ST_LOADED_BIT] = loaded;
    status_word[rf_cfg_pkg::ST_PROTO_LSB +: 3] = active_proto;
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr_q = aw_addr_q;
    next_w_held = w_held;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr_q) ? rf_cfg_pkg::RESP_OKAY : rf_cfg_pkg::RESP_SLVERR;
    end
    else if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? rf_cfg_pkg::RESP_OKAY : rf_cfg_pkg::RESP_SLVERR;
      next_rdata = 32'h0;
      case (araddr)
        rf_cfg_pkg::OFS_CTRL: next_rdata = {29'h0, proto_sel};
        rf_cfg_pkg::OFS_STATUS: next_rdata = status_word;
        rf_cfg_pkg::OFS_TX_ENABLE: next_rdata = {31'h0, tx_enable};
        rf_cfg_pkg::OFS_RX_DELAY: next_rdata = rx_delay;
        default:
        begin
          if (mapped(araddr) && araddr >= rf_cfg_pkg::OFS_SETTING0)
          begin
            next_rdata = setting_mem[3'((araddr - rf_cfg_pkg::OFS_SETTING0) >> 2)];
          end
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else if (ce)
    begin
      aw_held <= next_aw_held;
      aw_addr_q <= next_aw_addr_q;
      w_held <= next_w_held;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  always_comb
  begin
    next_state = state;
    next_proto_sel = proto_sel;
    next_active_proto = active_proto;
    next_idx = idx;
    next_tx_enable = tx_enable;
    next_done = done;
    next_refused = refused;
    next_bad_proto = bad_proto;
    next_loaded = loaded;
    next_setting_mem = setting_mem;
    next_rx_delay = rx_delay;
    next_setting_wr = '0;
    // Clears come first so that a flag raised in the same cycle survives.
    if (wr_fire && aw_addr_q == rf_cfg_pkg::OFS_STATUS && w_strb_q[0])
    begin
      if (w_data_q[rf_cfg_pkg::ST_DONE_BIT]) next_done = 1'b0;
      if (w_data_q[rf_cfg_pkg::ST_REFUSED_BIT]) next_refused = 1'b0;
      if (w_data_q[rf_cfg_pkg::ST_BAD_PROTO_BIT]) next_bad_proto = 1'b0;
    end
    if (wr_fire && aw_addr_q == rf_cfg_pkg::OFS_TX_ENABLE && w_strb_q[0])
    begin
      next_tx_enable = w_data_q[0];
    end
    case (state)
      rf_cfg_pkg::ST_IDLE:
      begin
        if (wr_fire && aw_addr_q == rf_cfg_pkg::OFS_CTRL)
        begin
          if (w_strb_q[0]) next_proto_sel = w_data_q[2:0];
          if (w_strb_q[1] && w_data_q[rf_cfg_pkg::CTRL_START_BIT])
          begin
            if (!req_ok)
            begin
              next_bad_proto = 1'b1;
            end
            else
            begin
              next_state = rf_cfg_pkg::ST_WRITE;
              next_active_proto = req_proto;
              next_idx = rf_cfg_pkg::IDX_TX_CLOCK;
              next_loaded = 1'b0;
            end
          end
        end
      end
      rf_cfg_pkg::ST_WRITE:
      begin
        next_setting_wr = '{valid: tbl_ok, index: idx, data: tbl_data}; // R1 R2 R3 R4 R5 R6 R7
        if (idx == rf_cfg_pkg::IDX_RX_DELAY)
        begin
          next_rx_delay = tbl_data; // R8
          next_state = rf_cfg_pkg::ST_FINISH;
        end
        else
        begin
          next_setting_mem[idx] = tbl_data;
          next_idx = idx + 3'h1;
        end
      end
      rf_cfg_pkg::ST_FINISH:
      begin
        next_done = 1'b1;
        next_loaded = 1'b1;
        next_state = rf_cfg_pkg::ST_IDLE;
      end
      default: next_state = rf_cfg_pkg::ST_IDLE;
    endcase
    // Commands that land while a load runs are dropped and flagged.
    if (state != rf_cfg_pkg::ST_IDLE && wr_fire && aw_addr_q == rf_cfg_pkg::OFS_CTRL)
    begin
      next_refused = 1'b1; // R9
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= rf_cfg_pkg::ST_IDLE;
      proto_sel <= 3'h0;
      active_proto <= 3'h0;
      idx <= 3'h0;
      tx_enable <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      bad_proto <= 1'b0;
      loaded <= 1'b0;
      rx_delay <= 32'h0;
      setting_wr <= '0;
      for (int i = 0; i < 6; i++) setting_mem[i] <= 32'h0;
    end
    else if (ce)
    begin
      state <= next_state;
      proto_sel <= next_proto_sel;
      active_proto <= next_active_proto;
      idx <= next_idx;
      tx_enable <= next_tx_enable;
      done <= next_done;
      refused <= next_refused;
      bad_proto <= next_bad_proto;
      loaded <= next_loaded;
      rx_delay <= next_rx_delay;
      setting_wr <= next_setting_wr;
      setting_mem <= next_setting_mem;
    end
  end

  a_a106_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    setting_wr.valid && active_proto == 3'h0 && setting_wr.index == 3'h4 |-> setting_wr.data == 32'hdbcf43)
    else $error("A106 drive value wrong");
  a_a212_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    setting_wr.valid && active_proto == 3'h1 && setting_wr.index == 3'h4 |-> setting_wr.data == 32'hdbcf043)
    else $error("A212 drive value wrong");
  a_a424_shape: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    setting_wr.valid && active_proto == 3'h2 && setting_wr.index == 3'h1 |-> setting_wr.data == 32'h650)
    else $error("A424 modulation shape wrong");
  a_a848_under: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    setting_wr.valid && active_proto == 3'h3 && setting_wr.index == 3'h2 |-> setting_wr.data == 32'h1)
    else $error("A848 undershoot wrong");
  a_b106_clock: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    setting_wr.valid && active_proto == 3'h4 && setting_wr.index == 3'h0 |-> setting_wr.data == 32'h8e)
    else $error("B106 tx clock wrong");
  a_b212_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    state == rf_cfg_pkg::ST_FINISH && active_proto == 3'h5 |=> setting_mem[4] == 32'h39c746)
    else $error("B212 drive value not stored");
  a_b424_over: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    state == rf_cfg_pkg::ST_FINISH && active_proto == 3'h6 |=> setting_mem[3] == 32'h1fe0013)
    else $error("B424 overshoot not stored");
  a_rx_timer_set: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // R8
    $rose(setting_wr.valid) |-> setting_wr.valid[*7] ##1 (!setting_wr.valid && done))
    else $error("Load did not end with the timer write");
  a_tx_held_busy: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    state != rf_cfg_pkg::ST_IDLE |-> !loaded && !rf_tx_on)
    else $error("Transmission allowed during load");
  a_cmd_refused: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // R9
    wr_fire && aw_addr_q == 8'h00 && state != rf_cfg_pkg::ST_IDLE |=> refused && $stable(active_proto))
    else $error("Command during load not refused");

  c_load_a106: cover property (@(posedge aclk) state == rf_cfg_pkg::ST_FINISH && active_proto == 3'h0);
  c_load_b424: cover property (@(posedge aclk) state == rf_cfg_pkg::ST_FINISH && active_proto == 3'h6);
  c_refused: cover property (@(posedge aclk) $rose(refused));
  c_tx_on: cover property (@(posedge aclk) $rose(rf_tx_on));

endmodule

// ### design/rf_cfg_pkg.sv
package rf_cfg_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SETTINGS = 6;
  localparam int unsigned NUM_WRITES = 7;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TX_ENABLE = 8'h08;
  localparam logic [7:0] OFS_RX_DELAY = 8'h0c;
  localparam logic [7:0] OFS_SETTING0 = 8'h10;

  // Field positions.
  localparam int unsigned CTRL_PROTO_LSB = 0;
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_REFUSED_BIT = 2;
  localparam int unsigned ST_BAD_PROTO_BIT = 3;
  localparam int unsigned ST_LOADED_BIT = 4;
  localparam int unsigned ST_PROTO_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Index of each written value; the last one is the reception-start delay timer.
  localparam logic [2:0] IDX_TX_CLOCK = 3'h0;
  localparam logic [2:0] IDX_MOD_SHAPE = 3'h1;
  localparam logic [2:0] IDX_UNDERSHOOT = 3'h2;
  localparam logic [2:0] IDX_OVERSHOOT = 3'h3;
  localparam logic [2:0] IDX_DRIVE = 3'h4;
  localparam logic [2:0] IDX_ANTENNA = 3'h5;
  localparam logic [2:0] IDX_RX_DELAY = 3'h6;

  typedef enum logic [2:0] {
    PROTO_A106 = 3'h0,
    PROTO_A212 = 3'h1,
    PROTO_A424 = 3'h2,
    PROTO_A848 = 3'h3,
    PROTO_B106 = 3'h4,
    PROTO_B212 = 3'h5,
    PROTO_B424 = 3'h6
  } proto_t;

  localparam logic [2:0] PROTO_LAST = 3'h6;

  // Rows by protocol; columns by write index.
  localparam logic [31:0] SETTING_TABLE [0:6][0:6] = '{
    '{32'h74, 32'h2350, 32'h17, 32'h0, 32'hdbcf43, 32'h10, 32'h40},
    '{32'h82, 32'h2350, 32'h17, 32'h0, 32'hdbcf043, 32'h10, 32'h40},
    '{32'h82, 32'h650, 32'h5, 32'h0, 32'hdbcf43, 32'h10, 32'h20},
    '{32'h82, 32'h150, 32'h1, 32'h0, 32'hf9ef45, 32'h10, 32'h10},
    '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h3a4756, 32'h10, 32'h80},
    '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h39c746, 32'h10, 32'h40},
    '{32'h78e, 32'h0, 32'h0, 32'h1fe0013, 32'h71cf54, 32'h10, 32'h20}
  };

  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [31:0] data;
  } setting_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_FINISH = 3'b100
  } load_state_t;

endpackage

// ### design/rf_protocol_table.sv
`timescale 1ns/1ps
module rf_protocol_table (
  input wire logic [2:0] proto, // Selected protocol code
  input wire logic [2:0] index, // Value index, 0 to 6
  output logic [31:0] data, // Value to load
  output logic proto_ok // Protocol code is supported
);

  always_comb
  begin
    proto_ok = (proto <= rf_cfg_pkg::PROTO_LAST);
    data = 32'h0;
    if (proto_ok && index <= rf_cfg_pkg::IDX_RX_DELAY)
    begin
      data = rf_cfg_pkg::SETTING_TABLE[proto][index]; // R1 R2 R3 R4 R5 R6 R7 R8
    end
  end

endmodule

// ### verification/rf_tx_settings_bank.sv
`timescale 1ns/1ps
module rf_tx_settings_bank (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire rf_cfg_pkg::setting_wr_t setting_wr, // One value written per cycle
  output logic [31:0] bank [0:6] // Values the transmitter holds
);
  // The transmitter keeps each value until a later load overwrites it, as the real one would.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 7; i++)
        bank[i] <= 32'h0;
    end
    else if (ce && setting_wr.valid)
    begin
      bank[setting_wr.index] <= setting_wr.data;
    end
  end
endmodule

// ### verification/rf_tx_protocol_config_loader_test.sv
`timescale 1ns/1ps
module rf_tx_protocol_config_loader_test;
  typedef struct packed {logic [31:0] d; logic [31:0] m;} rd_note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rf_tx_on;
  logic ce_q = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  rf_cfg_pkg::setting_wr_t setting_wr;
  logic [31:0] bank [0:6];
  logic [37:0] exp_wr [$];
  rd_note_t exp_rd [$];
  int fail_count = 0;
  int n_checks = 0;
  logic [15:0] rng = 16'h943e;
  logic [31:0] tbl [0:6][0:6] = '{
    '{32'h74, 32'h2350, 32'h17, 32'h0, 32'hdbcf43, 32'h10, 32'h40},
    '{32'h82, 32'h2350, 32'h17, 32'h0, 32'hdbcf043, 32'h10, 32'h40},
    '{32'h82, 32'h650, 32'h5, 32'h0, 32'hdbcf43, 32'h10, 32'h20},
    '{32'h82, 32'h150, 32'h1, 32'h0, 32'hf9ef45, 32'h10, 32'h10},
    '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h3a4756, 32'h10, 32'h80},
    '{32'h8e, 32'h0, 32'h0, 32'h0, 32'h39c746, 32'h10, 32'h40},
    '{32'h78e, 32'h0, 32'h0, 32'h1fe0013, 32'h71cf54, 32'h10, 32'h20}};

  always #20 aclk = ~aclk;

  rf_tx_protocol_config_loader uut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .setting_wr, .rf_tx_on);

  rf_tx_settings_bank far_end (.aclk, .aresetn, .ce, .setting_wr, .bank);

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string what, input logic [37:0] got, input logic [37:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("[ERR] %s expected handshake seen none", what);
    summarize();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
      begin
        // The response ready stays high between writes, so a following call never lowers and raises it at once.
        check("bresp", rs, er);
        return;
      end
    end
    hang("write");
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] rs;
    exp_rd.push_back(rd_note_t'{e, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rs = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
      begin
        check("rresp", rs, er);
        return;
      end
    end
    hang("read");
  endtask

  // Random clock-enable gaps stretch the load so that pulse counting cannot lean on fixed spacing.
  task automatic wait_load(input logic rnd);
    for (int k = 0; k < 300; k++)
    begin
      @(negedge aclk);
      if (rf_tx_on === 1'b1)
      begin
        check("pending writes", exp_wr.size(), 38'h0);
        @(posedge aclk);
        ce <= 1'b1;
        return;
      end
      @(posedge aclk);
      rng = lfsr_next(rng);
      ce <= !rnd || rng[0] || rng[1];
    end
    hang("load");
  endtask

  always @(posedge aclk)
    ce_q <= ce;

  always @(negedge aclk)
  begin
    rd_note_t n;
    if (aresetn && ce_q && setting_wr.valid)
    begin
      if (exp_wr.size() == 0)
        check("unexpected setting_wr", 1'b1, 1'b0);
      else
        check("setting_wr", setting_wr, exp_wr.pop_front());
    end
    if (aresetn && rvalid && rready)
    begin
      if (exp_rd.size() == 0)
        check("unexpected rvalid", 1'b1, 1'b0);
      else
      begin
        n = exp_rd.pop_front();
        check("rdata", rdata & n.m, n.d & n.m);
      end
    end
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(8'h04, 32'h0, 32'hffffffff, 2'b00);
    axi_read(8'h08, 32'h0, 32'hffffffff, 2'b00);
    $display("reset test done");
    axi_write(8'h08, 32'h1, 4'hf, 2'b00);
    @(negedge aclk);
    check("rf_tx_on before load", rf_tx_on, 1'b0);
    @(posedge aclk);
    for (int p = 0; p < 7; p++)
    begin
      for (int i = 0; i < 7; i++)
        exp_wr.push_back({1'b1, i[2:0], tbl[p][i]});
      axi_write(8'h00, {23'h0, 1'b1, 5'h0, p[2:0]}, 4'h3, 2'b00);
      @(negedge aclk);
      check("rf_tx_on", rf_tx_on, 1'b0);
      @(posedge aclk);
      if (p == 2)
        axi_write(8'h00, 32'h100, 4'h3, 2'b00);
      wait_load(p[0]);
      axi_read(8'h04, {21'h0, p[2:0], 4'h1, 1'b0, p == 2, 2'h2}, 32'hffffffff, 2'b00);
      axi_write(8'h04, 32'he, 4'h1, 2'b00);
      for (int i = 0; i < 6; i++)
        axi_read({i[5:0], 2'b00} + 8'h10, tbl[p][i], 32'hffffffff, 2'b00);
      axi_read(8'h0c, tbl[p][6], 32'hffffffff, 2'b00);
      for (int i = 0; i < 7; i++)
        check("bank", bank[i], tbl[p][i]);
      $display("protocol %0d test done", p);
    end
    axi_write(8'h0c, 32'hffffffff, 4'hf, 2'b00);
    axi_read(8'h0c, tbl[6][6], 32'hffffffff, 2'b00);
    rng = lfsr_next(rng);
    axi_write(8'h40, {rng, ~rng}, 4'hf, 2'b10);
    axi_read(8'h40, 32'h0, 32'hffffffff, 2'b10);
    axi_write(8'h08, 32'h0, 4'hf, 2'b00);
    @(negedge aclk);
    check("rf_tx_on", rf_tx_on, 1'b0);
    @(posedge aclk);
    axi_read(8'h08, 32'h0, 32'hffffffff, 2'b00);
    $display("register test done");
    axi_write(8'h00, 32'h107, 4'h3, 2'b00);
    repeat (12) @(posedge aclk);
    axi_read(8'h04, 32'h8, 32'h9, 2'b00);
    axi_read(8'h00, 32'h7, 32'hffffffff, 2'b00);
    $display("bad protocol test done");
    summarize();
  end
endmodule
